// ---- include/protect_tx_regs.vh ----
// Register indices, field positions, reset values and timing for the protection control block.
`ifndef PROTECT_TX_REGS_VH
`define PROTECT_TX_REGS_VH

// Register indices; the byte address is four times the index.
`define IDX_PROTECT_CONFIG 8'hc2
`define IDX_PROTECT_CONTROL 8'hc3
`define IDX_PROTECT_STATUS 8'hc4

// Configuration register fields.
`define CFG_LINK_VERIFY 7
`define CFG_ENHANCED_SIGNALLING 6
`define CFG_REPEATER_ENABLE 5
`define CFG_MODE_HI 4
`define CFG_MODE_LO 3
`define CFG_INIT_DELAY_ENABLE 2
`define CFG_DETECT_NEEDS_LOCK 1
`define CFG_AV_SILENCE_REQ 0
`define CFG_RESET 8'ha8

// Control register fields.
`define CTL_PROTECT_RESET_CMD 7
`define CTL_KEY_LIST_OK 5
`define CTL_RECEIVER_KEY_OK 4
`define CTL_CIPHER_OFF_CMD 3
`define CTL_CIPHER_ON 2
`define CTL_AUTH_OFF_CMD 1
`define CTL_AUTH_START 0
`define CTL_RESET 8'h00

// Status register fields.
`define STS_AUTHENTICATED 0
`define STS_RECEIVER_KEY_READY 1
`define STS_KEY_LIST_READY 2
`define STS_RX_DETECT 3
`define STS_DETECT_EVENT 4
`define STS_RX_LOCK 5
`define STS_ENCRYPTING 6
`define STS_INIT_WAIT_BUSY 7

// Encryption control modes.
`define MODE_AUTHENTICATED 2'h0
`define MODE_REGISTER 2'h1
`define MODE_ALWAYS 2'h2
`define MODE_PER_FRAME 2'h3

// AXI responses.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// Timing: initial computation wait and the clock rate in kHz.
`define INIT_WAIT_MS 100
`define CLK_KHZ 10000

`endif

// ---- rtl/content_protect_tx_control.v ----
// Control and configuration register bank of the content-protection transmitter.
`timescale 1ns/10ps
// Summary of operation
// - Repeater enable bit turns on the extra repeater authentication steps.
// - Two-bit mode selects authenticated, register, always or per-frame encryption.
// - A 100 ms wait before encryption applies only when its enable bit is set.
// - Detect event needs receiver detect, plus lock when the select bit is set.
// - Mute bit set with enhanced signalling freezes encryption controls; cleared returns to normal operation.
// - Reset command resets the transmitter, disables authentication and self-clears.
// - Controller sets key-list-ok after checking; device finishes and clears it.
// - Key-ok lets authentication continue; cleared when key-ready asserts; writing 0 ignored.
// - Cipher-off command sends plain video, keeps authentication, and self-clears.
// - Cipher-on sends encrypted data if authenticated, else blue screen.
// - In always-encrypt mode the cipher-on bit is read-only and reads 1.
// - Auth-off command disables authentication and self-clears.
// - Auth-start enables or restarts authentication; writing 0 has no effect.
// - Reading auth-start returns whether protection is currently enabled.
// - Enhanced signalling bit picks enhanced (1) or original (0) status signalling.
// - Key-ready flag sets when the key is read, clears when key-ok is set.
`include "protect_tx_regs.vh"

module content_protect_tx_control #(
    parameter ADDR_WIDTH = 12,
    parameter WAIT_WIDTH = 20,
    parameter [WAIT_WIDTH-1:0] INIT_WAIT_CYCLES = `INIT_WAIT_MS * `CLK_KHZ
) (
    input wire SYS_CLK_IN,
    input wire RST_IN,
    input wire S_AXI_AWVALID_IN,
    output wire S_AXI_AWREADY_OUT,
    input wire [ADDR_WIDTH-1:0] S_AXI_AWADDR_IN,
    input wire [2:0] S_AXI_AWPROT_IN,
    input wire S_AXI_WVALID_IN,
    output wire S_AXI_WREADY_OUT,
    input wire [31:0] S_AXI_WDATA_IN,
    input wire [3:0] S_AXI_WSTRB_IN,
    output reg S_AXI_BVALID_OUT,
    input wire S_AXI_BREADY_IN,
    output reg [1:0] S_AXI_BRESP_OUT,
    input wire S_AXI_ARVALID_IN,
    output wire S_AXI_ARREADY_OUT,
    input wire [ADDR_WIDTH-1:0] S_AXI_ARADDR_IN,
    input wire [2:0] S_AXI_ARPROT_IN,
    output reg S_AXI_RVALID_OUT,
    input wire S_AXI_RREADY_IN,
    output reg [31:0] S_AXI_RDATA_OUT,
    output reg [1:0] S_AXI_RRESP_OUT,
    input wire RX_DETECT_IN,
    input wire RX_LOCK_IN,
    input wire KEY_READ_DONE_IN,
    input wire LIST_READ_DONE_IN,
    input wire AUTH_OK_IN,
    input wire FRAME_ENCRYPT_IN,
    output reg AUTH_ENABLE_OUT,
    output reg AUTH_RESTART_OUT,
    output reg CIPHER_RESET_OUT,
    output reg REPEATER_MODE_OUT,
    output reg ENHANCED_SIGNALLING_OUT,
    output reg KEY_OK_OUT,
    output reg KEY_LIST_OK_OUT,
    output reg ENCRYPT_OUT,
    output reg BLUE_SCREEN_OUT,
    output reg AV_MUTE_OUT,
    output reg DETECT_EVENT_OUT
);

    // Byte address is the register index shifted past the two word-offset bits.
    localparam [ADDR_WIDTH-1:0] ADDR_CONFIG = {{(ADDR_WIDTH-10){1'b0}}, `IDX_PROTECT_CONFIG, 2'h0};
    localparam [ADDR_WIDTH-1:0] ADDR_CONTROL = {{(ADDR_WIDTH-10){1'b0}}, `IDX_PROTECT_CONTROL, 2'h0};
    localparam [ADDR_WIDTH-1:0] ADDR_STATUS = {{(ADDR_WIDTH-10){1'b0}}, `IDX_PROTECT_STATUS, 2'h0};

    reg [7:0] config_reg;
    reg cipher_on;
    reg receiver_key_ok;
    reg key_list_ok;
    reg auth_enabled;
    reg receiver_key_ready;
    reg key_list_ready;
    reg [WAIT_WIDTH-1:0] wait_count;
    reg wait_done;
    reg auth_seen;
    reg [7:0] read_byte;
    reg next_encrypt;
    reg next_blank;

    wire write_fire;
    wire write_byte;
    wire write_config;
    wire write_control;
    wire write_mapped;
    wire read_fire;
    wire read_mapped;
    wire [7:0] wbyte;
    wire [1:0] mode;
    wire always_mode;
    wire cmd_reset;
    wire cmd_auth_off;
    wire cmd_auth_start;
    wire cmd_cipher_off;
    wire cmd_key_ok;
    wire cmd_key_list_ok;
    wire auth_ready;
    wire mute_active;
    wire wait_busy;
    wire [7:0] status_byte;
    wire [7:0] control_byte;

    // The slave takes address and data together; it waits for both before answering.
    assign write_fire = S_AXI_AWVALID_IN && S_AXI_WVALID_IN && !S_AXI_BVALID_OUT;
    assign S_AXI_AWREADY_OUT = S_AXI_WVALID_IN && !S_AXI_BVALID_OUT;
    assign S_AXI_WREADY_OUT = S_AXI_AWVALID_IN && !S_AXI_BVALID_OUT;
    assign write_byte = write_fire && S_AXI_WSTRB_IN[0];
    assign write_config = write_byte && (S_AXI_AWADDR_IN == ADDR_CONFIG);
    assign write_control = write_byte && (S_AXI_AWADDR_IN == ADDR_CONTROL);
    assign write_mapped = (S_AXI_AWADDR_IN == ADDR_CONFIG) ||
        (S_AXI_AWADDR_IN == ADDR_CONTROL) || (S_AXI_AWADDR_IN == ADDR_STATUS);
    assign wbyte = S_AXI_WDATA_IN[7:0];

    assign S_AXI_ARREADY_OUT = !S_AXI_RVALID_OUT;
    assign read_fire = S_AXI_ARVALID_IN && !S_AXI_RVALID_OUT;
    assign read_mapped = (S_AXI_ARADDR_IN == ADDR_CONFIG) ||
        (S_AXI_ARADDR_IN == ADDR_CONTROL) || (S_AXI_ARADDR_IN == ADDR_STATUS);

    assign mode = config_reg[`CFG_MODE_HI:`CFG_MODE_LO];
    assign always_mode = (mode == `MODE_ALWAYS);

    // Command bits act only on a written 1; a written 0 never clears what they set.
    assign cmd_reset = write_control && wbyte[`CTL_PROTECT_RESET_CMD];
    assign cmd_auth_off = write_control && wbyte[`CTL_AUTH_OFF_CMD];
    assign cmd_auth_start = write_control && wbyte[`CTL_AUTH_START];
    assign cmd_cipher_off = write_control && wbyte[`CTL_CIPHER_OFF_CMD];
    assign cmd_key_ok = write_control && wbyte[`CTL_RECEIVER_KEY_OK];
    assign cmd_key_list_ok = write_control && wbyte[`CTL_KEY_LIST_OK];

    // Mute is honoured only with enhanced signalling, so a stray write cannot freeze the cipher.
    assign mute_active = config_reg[`CFG_AV_SILENCE_REQ] &&
        config_reg[`CFG_ENHANCED_SIGNALLING];

    assign wait_busy = config_reg[`CFG_INIT_DELAY_ENABLE] && AUTH_OK_IN && !wait_done;
    assign auth_ready = auth_enabled && AUTH_OK_IN && !wait_busy;

    assign control_byte = {1'b0, 1'b0, key_list_ok, receiver_key_ok, 1'b0,
        (cipher_on || always_mode), 1'b0, auth_enabled};
    assign status_byte = {wait_busy, ENCRYPT_OUT, RX_LOCK_IN, DETECT_EVENT_OUT,
        RX_DETECT_IN, key_list_ready, receiver_key_ready, auth_ready};

    always @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            config_reg <= `CFG_RESET;
        end else if (write_config) begin
            config_reg <= wbyte;
        end
    end

    always @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            auth_enabled <= 1'b0;
            AUTH_RESTART_OUT <= 1'b0;
            CIPHER_RESET_OUT <= 1'b0;
        end else begin
            AUTH_RESTART_OUT <= cmd_auth_start && !cmd_reset && !cmd_auth_off;
            CIPHER_RESET_OUT <= cmd_reset;
            if (cmd_reset || cmd_auth_off) begin
                auth_enabled <= 1'b0;
            end else if (cmd_auth_start) begin
                auth_enabled <= 1'b1;
            end
        end
    end

    // Cipher-off clears the stored enable but leaves authentication untouched.
    always @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            cipher_on <= 1'b0;
        end else if (cmd_reset || cmd_cipher_off) begin
            cipher_on <= 1'b0;
        end else if (write_control && !always_mode) begin
            cipher_on <= wbyte[`CTL_CIPHER_ON];
        end
    end

    // Key handshakes: each ready flag is set by the engine and a new event wins over a clear.
    always @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            receiver_key_ready <= 1'b0;
            key_list_ready <= 1'b0;
            receiver_key_ok <= 1'b0;
            key_list_ok <= 1'b0;
        end else begin
            if (KEY_READ_DONE_IN) begin
                receiver_key_ready <= 1'b1;
            end else if (cmd_key_ok || cmd_reset) begin
                receiver_key_ready <= 1'b0;
            end
            if (LIST_READ_DONE_IN) begin
                key_list_ready <= 1'b1;
            end else if (cmd_key_list_ok || cmd_reset) begin
                key_list_ready <= 1'b0;
            end
            if (KEY_READ_DONE_IN || cmd_reset) begin
                receiver_key_ok <= 1'b0;
            end else if (cmd_key_ok) begin
                receiver_key_ok <= 1'b1;
            end
            // The engine consumes the list approval in one cycle, so it reads back as 0.
            key_list_ok <= cmd_key_list_ok && !cmd_reset;
        end
    end

    // One-shot wait after each authentication success; restarts re-arm it.
    always @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            wait_count <= {WAIT_WIDTH{1'b0}};
            wait_done <= 1'b0;
        end else if (!AUTH_OK_IN || cmd_reset || AUTH_RESTART_OUT) begin
            wait_count <= {WAIT_WIDTH{1'b0}};
            wait_done <= 1'b0;
        end else if (config_reg[`CFG_INIT_DELAY_ENABLE] && !wait_done) begin
            if (wait_count == INIT_WAIT_CYCLES - 1'b1) begin
                wait_done <= 1'b1;
            end else begin
                wait_count <= wait_count + 1'b1;
            end
        end
    end

    always @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            auth_seen <= 1'b0;
        end else begin
            auth_seen <= auth_ready;
        end
    end

    // Encryption decision per mode.
    always @* begin
        next_encrypt = 1'b0;
        next_blank = 1'b0;
        case (mode)
            `MODE_AUTHENTICATED: begin
                next_encrypt = auth_ready;
            end
            `MODE_REGISTER: begin
                next_encrypt = cipher_on && auth_ready;
                next_blank = cipher_on && !auth_ready;
            end
            `MODE_ALWAYS: begin
                next_encrypt = auth_ready;
                next_blank = !auth_ready;
            end
            `MODE_PER_FRAME: begin
                next_encrypt = FRAME_ENCRYPT_IN && auth_ready;
                next_blank = FRAME_ENCRYPT_IN && !auth_ready;
            end
            default: begin
                next_encrypt = 1'b0;
                next_blank = 1'b0;
            end
        endcase
    end

    // While muted the encryption outputs hold, ignoring every status control except the reset command, which clears them.
    always @(posedge SYS_CLK_IN) begin
        if (RST_IN || cmd_reset) begin
            ENCRYPT_OUT <= 1'b0;
            BLUE_SCREEN_OUT <= 1'b0;
        end else if (!mute_active) begin
            ENCRYPT_OUT <= next_encrypt;
            BLUE_SCREEN_OUT <= next_blank;
        end
    end

    always @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            AUTH_ENABLE_OUT <= 1'b0;
            REPEATER_MODE_OUT <= 1'b0;
            ENHANCED_SIGNALLING_OUT <= 1'b0;
            KEY_OK_OUT <= 1'b0;
            KEY_LIST_OK_OUT <= 1'b0;
            AV_MUTE_OUT <= 1'b0;
            DETECT_EVENT_OUT <= 1'b0;
        end else begin
            AUTH_ENABLE_OUT <= auth_enabled;
            REPEATER_MODE_OUT <= config_reg[`CFG_REPEATER_ENABLE];
            ENHANCED_SIGNALLING_OUT <= config_reg[`CFG_ENHANCED_SIGNALLING];
            KEY_OK_OUT <= receiver_key_ok;
            KEY_LIST_OK_OUT <= key_list_ok && config_reg[`CFG_REPEATER_ENABLE];
            AV_MUTE_OUT <= mute_active;
            DETECT_EVENT_OUT <= RX_DETECT_IN &&
                (!config_reg[`CFG_DETECT_NEEDS_LOCK] || RX_LOCK_IN);
        end
    end

    always @* begin
        read_byte = 8'h00;
        if (S_AXI_ARADDR_IN == ADDR_CONFIG) begin
            read_byte = config_reg;
        end else if (S_AXI_ARADDR_IN == ADDR_CONTROL) begin
            read_byte = control_byte;
        end else if (S_AXI_ARADDR_IN == ADDR_STATUS) begin
            read_byte = status_byte;
        end
    end

    always @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            S_AXI_BVALID_OUT <= 1'b0;
            S_AXI_BRESP_OUT <= `RESP_OKAY;
        end else if (write_fire) begin
            S_AXI_BVALID_OUT <= 1'b1;
            S_AXI_BRESP_OUT <= write_mapped ? `RESP_OKAY : `RESP_SLVERR;
        end else if (S_AXI_BREADY_IN) begin
            S_AXI_BVALID_OUT <= 1'b0;
        end
    end

    always @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            S_AXI_RVALID_OUT <= 1'b0;
            S_AXI_RDATA_OUT <= 32'h0000_0000;
            S_AXI_RRESP_OUT <= `RESP_OKAY;
        end else if (read_fire) begin
            S_AXI_RVALID_OUT <= 1'b1;
            S_AXI_RDATA_OUT <= {24'h00_0000, read_byte};
            S_AXI_RRESP_OUT <= read_mapped ? `RESP_OKAY : `RESP_SLVERR;
        end else if (S_AXI_RREADY_IN) begin
            S_AXI_RVALID_OUT <= 1'b0;
        end
    end

endmodule

// ---- tb/protect_ctl_sva.sv ----
// Port-level checks for the protection control register block.
`timescale 1ns/10ps
module protect_ctl_sva #(
    parameter ADDR_WIDTH = 12
) (
    input logic SYS_CLK_IN,
    input logic RST_IN,
    input logic S_AXI_AWVALID_IN,
    input logic [ADDR_WIDTH-1:0] S_AXI_AWADDR_IN,
    input logic S_AXI_WVALID_IN,
    input logic [31:0] S_AXI_WDATA_IN,
    input logic [3:0] S_AXI_WSTRB_IN,
    input logic S_AXI_BVALID_OUT,
    input logic KEY_READ_DONE_IN,
    input logic AUTH_ENABLE_OUT,
    input logic AUTH_RESTART_OUT,
    input logic CIPHER_RESET_OUT,
    input logic REPEATER_MODE_OUT,
    input logic ENHANCED_SIGNALLING_OUT,
    input logic KEY_OK_OUT,
    input logic KEY_LIST_OK_OUT,
    input logic ENCRYPT_OUT,
    input logic BLUE_SCREEN_OUT,
    input logic AV_MUTE_OUT
);
    default clocking dc @(posedge SYS_CLK_IN);
    endclocking
    default disable iff (RST_IN);
    logic take;
    logic wr_cfg;
    logic wr_ctl;
    logic [7:0] wd;
    assign wd = S_AXI_WDATA_IN[7:0];
    assign take = S_AXI_AWVALID_IN && S_AXI_WVALID_IN && !S_AXI_BVALID_OUT && S_AXI_WSTRB_IN[0];
    assign wr_cfg = take && S_AXI_AWADDR_IN == 12'h308;
    assign wr_ctl = take && S_AXI_AWADDR_IN == 12'h30c;
    a_start_pulse: assert property (wr_ctl && wd[0] && !wd[7] && !wd[1] |=> AUTH_RESTART_OUT ##1 !AUTH_RESTART_OUT)
        else $error("restart pulse missing after start write");
    a_start_enables: assert property (wr_ctl && wd[0] && !wd[7] && !wd[1] |=> ##1 AUTH_ENABLE_OUT)
        else $error("authentication not enabled after start write");
    a_reset_cmd: assert property (wr_ctl && wd[7] |=> CIPHER_RESET_OUT ##1 !CIPHER_RESET_OUT && !AUTH_ENABLE_OUT)
        else $error("reset command did not pulse and disable");
    a_auth_off: assert property (wr_ctl && wd[1] && !wd[0] |=> ##1 !AUTH_ENABLE_OUT)
        else $error("authentication still enabled after off command");
    a_list_ok_pulse: assert property (wr_ctl && wd[5] && !wd[7] && REPEATER_MODE_OUT |-> ##[1:2] KEY_LIST_OK_OUT)
        else $error("key list accept not passed on");
    a_list_self_clear: assert property (KEY_LIST_OK_OUT |=> !KEY_LIST_OK_OUT)
        else $error("key list accept held longer than one cycle");
    a_key_ok_set: assert property (wr_ctl && wd[4] && !wd[7] && !KEY_READ_DONE_IN |-> ##[1:2] KEY_OK_OUT)
        else $error("key accept not passed on");
    a_key_ok_drop: assert property (KEY_READ_DONE_IN |-> ##[1:2] !KEY_OK_OUT)
        else $error("key accept not cleared by key ready");
    a_cfg_outputs: assert property (wr_cfg |=> ##1 REPEATER_MODE_OUT == $past(wd[5], 2)
        && ENHANCED_SIGNALLING_OUT == $past(wd[6], 2))
        else $error("configuration outputs do not follow write");
    a_mute_freeze: assert property (AV_MUTE_OUT && $past(AV_MUTE_OUT) && !CIPHER_RESET_OUT
        |-> $stable(ENCRYPT_OUT) && $stable(BLUE_SCREEN_OUT))
        else $error("encryption changed during mute");
    a_blue_excl: assert property (BLUE_SCREEN_OUT |-> !ENCRYPT_OUT)
        else $error("blue screen while encrypting");
endmodule
bind content_protect_tx_control protect_ctl_sva #(.ADDR_WIDTH(ADDR_WIDTH)) u_protect_ctl_sva (.*);

// ---- tb/auth_engine_model.sv ----
// Behavioural model of the authentication engine facing the control block.
`timescale 1ns/10ps
module auth_engine_model #(
    parameter DELAY = 6
) (
    input wire clk,
    input wire rst,
    input wire restart,
    input wire wipe,
    input wire enabled,
    input wire key_ok,
    input wire list_ok,
    input wire repeater,
    output logic key_done,
    output logic list_done,
    output logic auth_ok
);
    int cnt;
    int lcnt;
    logic key_ok_d;
    // The key and list reads take DELAY cycles, so the controller must really wait.
    always @(posedge clk) begin
        key_done <= 1'b0;
        list_done <= 1'b0;
        key_ok_d <= key_ok;
        if (cnt > 0) cnt <= cnt - 1;
        if (cnt == 1) key_done <= 1'b1;
        if (lcnt > 0) lcnt <= lcnt - 1;
        if (lcnt == 1) list_done <= 1'b1;
        if (key_ok && !key_ok_d && repeater) lcnt <= DELAY;
        if ((key_ok && !key_ok_d && !repeater) || list_ok) auth_ok <= 1'b1;
        if (restart) cnt <= DELAY;
        if (rst || wipe || !enabled || restart) auth_ok <= 1'b0;
        if (rst || wipe) begin
            cnt <= 0;
            lcnt <= 0;
        end
    end
endmodule

// ---- tb/tb_content_protect_tx_control.sv ----
// Self-checking bench for the protection control register block.
`timescale 1ns/10ps
module tb_content_protect_tx_control;
    localparam logic [11:0] CFG = 12'h308;
    localparam logic [11:0] CTL = 12'h30c;
    localparam logic [11:0] STS = 12'h310;
    logic SYS_CLK_IN, RST_IN, S_AXI_AWVALID_IN, S_AXI_WVALID_IN, S_AXI_BREADY_IN;
    logic S_AXI_ARVALID_IN, S_AXI_RREADY_IN, RX_DETECT_IN, RX_LOCK_IN, FRAME_ENCRYPT_IN;
    logic S_AXI_AWREADY_OUT, S_AXI_WREADY_OUT, S_AXI_BVALID_OUT, S_AXI_ARREADY_OUT;
    logic S_AXI_RVALID_OUT, KEY_READ_DONE_IN, LIST_READ_DONE_IN, AUTH_OK_IN;
    logic AUTH_ENABLE_OUT, AUTH_RESTART_OUT, CIPHER_RESET_OUT, REPEATER_MODE_OUT;
    logic ENHANCED_SIGNALLING_OUT, KEY_OK_OUT, KEY_LIST_OK_OUT, ENCRYPT_OUT;
    logic BLUE_SCREEN_OUT, AV_MUTE_OUT, DETECT_EVENT_OUT;
    logic [11:0] S_AXI_AWADDR_IN, S_AXI_ARADDR_IN;
    logic [2:0] S_AXI_AWPROT_IN, S_AXI_ARPROT_IN;
    logic [31:0] S_AXI_WDATA_IN, S_AXI_RDATA_OUT;
    logic [3:0] S_AXI_WSTRB_IN;
    logic [1:0] S_AXI_BRESP_OUT, S_AXI_RRESP_OUT;
    logic [33:0] rq[$];
    logic [7:0] v;
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;
    int seed = 32'hf36406ed;
    content_protect_tx_control #(.INIT_WAIT_CYCLES(20'h10)) u_content_protect_tx_control (.*);
    auth_engine_model #(.DELAY(30)) u_auth_engine_model (.clk(SYS_CLK_IN), .rst(RST_IN),
        .restart(AUTH_RESTART_OUT), .wipe(CIPHER_RESET_OUT), .enabled(AUTH_ENABLE_OUT),
        .key_ok(KEY_OK_OUT), .list_ok(KEY_LIST_OK_OUT), .repeater(REPEATER_MODE_OUT),
        .key_done(KEY_READ_DONE_IN), .list_done(LIST_READ_DONE_IN), .auth_ok(AUTH_OK_IN));
    initial begin
        SYS_CLK_IN = 1'b0;
        forever #50 SYS_CLK_IN = ~SYS_CLK_IN;
    end
    task automatic complete_run();
        if (miscompares == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [33:0] e, input logic [33:0] g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value at %0t: expected %h got %h", $time, e, g);
        end
    endtask
    // One transfer at a time: w selects a write, r is the expected response code.
    task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
                        input logic [1:0] r);
        rq.push_back(w ? {r, 32'h0} : {r, 24'h0, d});
        S_AXI_AWADDR_IN <= a;
        S_AXI_ARADDR_IN <= a;
        S_AXI_WDATA_IN <= {24'h0, d};
        S_AXI_AWVALID_IN <= w;
        S_AXI_WVALID_IN <= w;
        S_AXI_ARVALID_IN <= !w;
        S_AXI_BREADY_IN <= w;
        S_AXI_RREADY_IN <= !w;
        do @(negedge SYS_CLK_IN); while (w ? !S_AXI_WREADY_OUT : !S_AXI_ARREADY_OUT);
        @(posedge SYS_CLK_IN);
        S_AXI_AWVALID_IN <= 1'b0;
        S_AXI_WVALID_IN <= 1'b0;
        S_AXI_ARVALID_IN <= 1'b0;
        do @(negedge SYS_CLK_IN); while (!(S_AXI_BVALID_OUT || S_AXI_RVALID_OUT));
        @(posedge SYS_CLK_IN);
    endtask
    always @(posedge SYS_CLK_IN) begin
        if (S_AXI_RVALID_OUT && S_AXI_RREADY_IN)
            check(rq.pop_front(), {S_AXI_RRESP_OUT, S_AXI_RDATA_OUT});
        if (S_AXI_BVALID_OUT && S_AXI_BREADY_IN)
            check(rq.pop_front(), {S_AXI_BRESP_OUT, 32'h0});
    end
    always @(posedge SYS_CLK_IN) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            complete_run();
        end
    end
    initial begin
        {RST_IN, S_AXI_AWVALID_IN, S_AXI_WVALID_IN, S_AXI_BREADY_IN} = 4'h8;
        {S_AXI_ARVALID_IN, S_AXI_RREADY_IN, RX_DETECT_IN, RX_LOCK_IN, FRAME_ENCRYPT_IN} = 5'h0;
        {S_AXI_AWADDR_IN, S_AXI_ARADDR_IN, S_AXI_WDATA_IN} = 56'h0;
        {S_AXI_AWPROT_IN, S_AXI_ARPROT_IN, S_AXI_WSTRB_IN} = 10'h00f;
        repeat (4) @(posedge SYS_CLK_IN);
        RST_IN <= 1'b0;
        xfer(0, CFG, 8'ha8, 2'h0);
        xfer(0, CTL, 8'h00, 2'h0);
        xfer(0, 12'h314, 8'h00, 2'h2);
        xfer(1, 12'h314, 8'hff, 2'h2);
        for (int m = 0; m < 4; m++) begin
            v = {3'b001, m[1:0], 3'b000};
            xfer(1, CFG, v, 2'h0);
            xfer(0, CFG, v, 2'h0);
            xfer(0, CTL, (m == 2) ? 8'h04 : 8'h00, 2'h0);
        end
        repeat (4) begin
            v = 8'($random(seed));
            xfer(1, CFG, v, 2'h0);
            xfer(0, CFG, v, 2'h0);
        end
        xfer(1, CFG, 8'h28, 2'h0);
        xfer(1, CTL, 8'h01, 2'h0);
        xfer(0, CTL, 8'h01, 2'h0);
        xfer(1, CTL, 8'h00, 2'h0);
        xfer(0, CTL, 8'h01, 2'h0);
        do @(negedge SYS_CLK_IN); while (!KEY_READ_DONE_IN);
        @(posedge SYS_CLK_IN);
        xfer(0, STS, 8'h02, 2'h0);
        xfer(1, CTL, 8'h10, 2'h0);
        do @(negedge SYS_CLK_IN); while (!LIST_READ_DONE_IN);
        @(posedge SYS_CLK_IN);
        xfer(0, STS, 8'h04, 2'h0);
        xfer(1, CTL, 8'h20, 2'h0);
        xfer(1, CTL, 8'h04, 2'h0);
        xfer(0, STS, 8'h41, 2'h0);
        xfer(1, CFG, 8'h2a, 2'h0);
        RX_DETECT_IN <= 1'b1;
        repeat (2) @(posedge SYS_CLK_IN);
        xfer(0, STS, 8'h49, 2'h0);
        RX_LOCK_IN <= 1'b1;
        repeat (2) @(posedge SYS_CLK_IN);
        xfer(0, STS, 8'h79, 2'h0);
        xfer(1, CTL, 8'h08, 2'h0);
        xfer(0, STS, 8'h39, 2'h0);
        xfer(1, CFG, 8'h69, 2'h0);
        xfer(1, CTL, 8'h04, 2'h0);
        xfer(0, STS, 8'h39, 2'h0);
        xfer(1, CTL, 8'h80, 2'h0);
        xfer(0, CTL, 8'h00, 2'h0);
        xfer(1, CFG, 8'h28, 2'h0);
        xfer(1, CTL, 8'h05, 2'h0);
        xfer(1, CTL, 8'h06, 2'h0);
        xfer(0, CTL, 8'h04, 2'h0);
        complete_run();
    end
endmodule
